// *** rtl/rst_ctl_pkg.sv ***
// Purpose: Shared constants and carrier types for the reset, stop and halt controller
// Assumes: One system clock at 250 MHz
// Notes:   Timing figures are kept in their own units and turned into cycle counts here
package rst_ctl_pkg;

  localparam int unsigned CLK_PERIOD_NS     = 4;
  localparam int unsigned RST_HOLD_NS       = 1000;
  localparam int unsigned XTAL_EXTRA_NS     = 4000;
  localparam int unsigned SMR_DELAY_NS      = 400;
  localparam int unsigned SMR_MIN_PULSE_NS  = 40;

  localparam int unsigned RST_HOLD_CYC      = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned XTAL_EXTRA_CYC    = (XTAL_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SMR_DELAY_CYC     = (SMR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SMR_MIN_PULSE_CYC = (SMR_MIN_PULSE_NS + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS;

  localparam int unsigned CNT_W             = 12;
  localparam int unsigned GPIO_W            = 24;
  localparam int unsigned PERIPH_W          = 8;

  localparam int unsigned DBG_CTL_RESET_BIT = 0;

  typedef enum logic [2:0] {
    RST_POR,
    RST_BROWNOUT,
    RST_WATCHDOG,
    RST_PIN,
    RST_DEBUG
  } rst_src_idx_t;

  typedef struct packed {
    logic por;
    logic brownout;
    logic watchdog;
    logic pin;
    logic debug;
  } rst_cause_t;

  typedef struct packed {
    logic watchdog_timeout_flag;
    logic stop_recovery;
    logic stop_short_pulse;
  } wake_flags_t;

endpackage

// *** rtl/sync_stretch.sv ***
// Purpose: Two-flop synchroniser with a hold stretch of hold_i cycles after release
// Assumes: Input asynchronous; clock enable freezes the counter
// Notes:   First flop feeds only the second flop
module sync_stretch #(
  parameter int unsigned CNT_W = 12
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             src_i,
  input  wire logic [CNT_W-1:0] hold_i,
  output logic                  out_o
);

  logic             meta_ff;
  logic             sync_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             out_ff;
  logic             nxt_out;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_out = out_ff;
    if (sync_ff) begin
      nxt_cnt = hold_i;
      nxt_out = 1'b1;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - 1'b1;
      nxt_out = 1'b1;
    end else begin
      nxt_out = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      cnt_ff  <= '0;
      out_ff  <= 1'b1;
    end else if (ce_i) begin
      meta_ff <= src_i;
      sync_ff <= meta_ff;
      cnt_ff  <= nxt_cnt;
      out_ff  <= nxt_out;
    end
  end

  assign out_o = out_ff;

endmodule

// *** rtl/reset_stop_halt_controller.sv ***
// Purpose: Gathers reset sources, runs stop recovery and halt control for an 8-bit MCU
// Assumes: Inputs synchronous except reset sources, which are synchronised here
// Notes:   Reset pin is open drain: output low with enable high while in reset
import rst_ctl_pkg::*;

// Contract
// - Power-on or brownout raises system reset
// - Watchdog resets only when reset option selected
// - Reset pin acts only when alternate enabled
// - Debugger control bit 0 issues reset
// - Pin low resets; device drives pin low
// - Pin pulled low during any internal reset
// - Crystal option lengthens reset duration
// - STOP wakes on watchdog or enabled pin
// - Stop recovery flag set after recovery
// - Watchdog in STOP sets both flags
// - Interrupt watchdog wakes then requests service
// - Reset pin in STOP gives full reset
// - Debug pin low in STOP resets
// - Either edge on source pin wakes
// - Short pulse no wake; status flag set
// - Input data latched only if level persists
// - Halt stops CPU; clocks, peripherals run
// - Watchdog oscillator and count run in HALT
// - HALT exits on interrupt, watchdog, resets
// - Each peripheral disabled individually by software
// - Disable gates peripheral clock or power
module reset_stop_halt_controller #(
  parameter int unsigned GPIO_N    = GPIO_W,
  parameter int unsigned PERIPH_N  = PERIPH_W,
  parameter int unsigned HOLD_CYC  = RST_HOLD_CYC,
  parameter int unsigned XTAL_CYC  = XTAL_EXTRA_CYC,
  parameter int unsigned SMR_CYC   = SMR_DELAY_CYC,
  parameter int unsigned PULSE_CYC = SMR_MIN_PULSE_CYC
) (
  input  wire logic                REF_CLK_I,
  input  wire logic                RST_I,
  input  wire logic                CE_I,
  input  wire logic                POR_I,
  input  wire logic                BROWNOUT_DETECT_I,
  input  wire logic                WDT_TIMEOUT_I,
  input  wire logic                WATCHDOG_RESET_SELECT_OPTION_I,
  input  wire logic                WDT_ENABLE_I,
  input  wire logic                RESET_PIN_I,
  input  wire logic                RESET_PIN_ALT_EN_I,
  input  wire logic [7:0]          DEBUGGER_CONTROL_REGISTER_I,
  input  wire logic                SERIAL_DEBUG_PIN_I,
  input  wire logic                XTAL_OPTION_I,
  input  wire logic                STOP_REQ_I,
  input  wire logic                HALT_REQ_I,
  input  wire logic                IRQ_PENDING_I,
  input  wire logic                IRQ_GLOBAL_EN_I,
  input  wire logic [GPIO_N-1:0]   GPIO_I,
  input  wire logic [GPIO_N-1:0]   SMR_SRC_EN_I,
  input  wire logic                FLAG_CLR_I,
  input  wire logic [PERIPH_N-1:0] PERIPH_DISABLE_I,
  output logic                     RESET_PIN_O,
  output logic                     RESET_PIN_OE_O,
  output logic                     SYS_RESET_O,
  output rst_ctl_pkg::rst_cause_t  RESET_CAUSE_O,
  output rst_ctl_pkg::wake_flags_t WAKE_FLAGS_O,
  output logic                     CPU_RUN_O,
  output logic                     SYS_CLK_EN_O,
  output logic                     WDT_CLK_EN_O,
  output logic                     WDT_IRQ_O,
  output logic [GPIO_N-1:0]        PORT_INPUT_DATA_REGISTER_O,
  output logic                     STOP_O,
  output logic                     HALT_O,
  output logic [PERIPH_N-1:0]      PERIPH_CLK_EN_O,
  output logic [PERIPH_N-1:0]      PERIPH_PWR_EN_O
);

  import rst_ctl_pkg::*;

  typedef enum logic [1:0] {
    S_RUN,
    S_HALT,
    S_STOP,
    S_RECOVER
  } pwr_state_t;

  localparam logic [CNT_W-1:0] HOLD_N     = CNT_W'(HOLD_CYC);
  localparam logic [CNT_W-1:0] HOLD_XTAL  = CNT_W'(HOLD_CYC + XTAL_CYC);
  localparam logic [CNT_W-1:0] SMR_N      = CNT_W'(SMR_CYC);
  localparam logic [CNT_W-1:0] PULSE_N    = CNT_W'(PULSE_CYC);

  logic             async_src;
  logic             rst_stretched;
  logic [CNT_W-1:0] hold_sel;
  logic             in_stop;
  logic             wdt_rst_en;
  logic             pin_rst_en;
  logic             stop_pin_rst;
  pwr_state_t       state_ff;
  pwr_state_t       nxt_state;
  logic             sys_rst_ff;

  // Watchdog and reset pin sources are gated by their options first; all are synchronised there
  assign in_stop      = (state_ff == S_STOP) || (state_ff == S_RECOVER);
  assign wdt_rst_en   = WDT_TIMEOUT_I && WATCHDOG_RESET_SELECT_OPTION_I && !in_stop;
  // Our own pull-down is masked, else an enabled pin would hold reset for ever
  assign pin_rst_en   = !RESET_PIN_I && RESET_PIN_ALT_EN_I && !sys_rst_ff;
  assign stop_pin_rst = in_stop && !SERIAL_DEBUG_PIN_I;
  assign async_src    = POR_I || BROWNOUT_DETECT_I
                        || wdt_rst_en || pin_rst_en
                        || DEBUGGER_CONTROL_REGISTER_I[DBG_CTL_RESET_BIT]
                        || stop_pin_rst;
  assign hold_sel     = XTAL_OPTION_I ? HOLD_XTAL : HOLD_N;

  sync_stretch #(
    .CNT_W (CNT_W)
  ) u_rst_sync (
    .clk_i  (REF_CLK_I),
    .rst_i  (RST_I),
    .ce_i   (CE_I),
    .src_i  (async_src),
    .hold_i (hold_sel),
    .out_o  (rst_stretched)
  );

  // Power state machine
  logic [CNT_W-1:0]  smr_cnt_ff;
  logic [CNT_W-1:0]  nxt_smr_cnt;
  logic [CNT_W-1:0]  pulse_cnt_ff;
  logic [CNT_W-1:0]  nxt_pulse_cnt;
  logic [GPIO_N-1:0] gpio_ref_ff;
  logic [GPIO_N-1:0] nxt_gpio_ref;
  logic [GPIO_N-1:0] pin_data_ff;
  logic [GPIO_N-1:0] nxt_pin_data;
  logic [GPIO_N-1:0] pin_change;
  logic              wake_by_wdt_ff;
  logic              nxt_wake_by_wdt;
  logic              wake_by_pin_ff;
  logic              nxt_wake_by_pin;
  logic              gpio_wake;
  logic              pulse_still;
  wake_flags_t       flags_ff;
  wake_flags_t       nxt_flags;
  rst_cause_t        cause_ff;
  rst_cause_t        nxt_cause;
  logic              wdt_irq_ff;
  logic              nxt_wdt_irq;

  // Per-pin change detect against the level seen on entry to STOP
  genvar g;
  generate
    for (g = 0; g < GPIO_N; g++) begin : g_pin
      assign pin_change[g] = SMR_SRC_EN_I[g] && (GPIO_I[g] != gpio_ref_ff[g]);
    end
  endgenerate
  assign gpio_wake   = |pin_change;
  assign pulse_still = gpio_wake;

  always_comb begin
    nxt_state       = state_ff;
    nxt_smr_cnt     = smr_cnt_ff;
    nxt_pulse_cnt   = pulse_cnt_ff;
    nxt_gpio_ref    = gpio_ref_ff;
    nxt_pin_data    = pin_data_ff;
    nxt_wake_by_wdt = wake_by_wdt_ff;
    nxt_wake_by_pin = wake_by_pin_ff;
    nxt_flags       = flags_ff;
    nxt_wdt_irq     = 1'b0;
    if (FLAG_CLR_I) begin
      nxt_flags = '0;
    end
    case (state_ff)
      S_RUN: begin
        nxt_pin_data = GPIO_I;
        nxt_gpio_ref = GPIO_I;
        if (STOP_REQ_I) begin
          nxt_state = S_STOP;
        end else if (HALT_REQ_I) begin
          nxt_state = S_HALT;
        end
      end
      S_HALT: begin
        nxt_pin_data = GPIO_I;
        // Watchdog of either type or an interrupt ends HALT; resets act via reset path
        if (IRQ_PENDING_I || WDT_TIMEOUT_I) begin
          nxt_state   = S_RUN;
          nxt_wdt_irq = WDT_TIMEOUT_I && !WATCHDOG_RESET_SELECT_OPTION_I;
        end
      end
      S_STOP: begin
        // Input data register frozen in STOP
        if (WDT_TIMEOUT_I || gpio_wake) begin
          nxt_state       = S_RECOVER;
          nxt_smr_cnt     = SMR_N;
          nxt_pulse_cnt   = '0;
          nxt_wake_by_wdt = WDT_TIMEOUT_I;
          nxt_wake_by_pin = gpio_wake && !WDT_TIMEOUT_I;
        end
      end
      S_RECOVER: begin
        if (pulse_still && pulse_cnt_ff != PULSE_N) begin
          nxt_pulse_cnt = pulse_cnt_ff + 1'b1;
        end
        if (smr_cnt_ff != '0) begin
          nxt_smr_cnt = smr_cnt_ff - 1'b1;
        end else if (wake_by_pin_ff && pulse_cnt_ff != PULSE_N) begin
          // Pulse too short: back to STOP, report it in status
          nxt_state                  = S_STOP;
          nxt_flags.stop_short_pulse = 1'b1;
        end else begin
          // Registers are kept; only clock and CPU restart
          nxt_state                = S_RUN;
          nxt_flags.stop_recovery  = 1'b1;
          nxt_pin_data             = GPIO_I;
          if (wake_by_wdt_ff) begin
            nxt_flags.watchdog_timeout_flag = 1'b1;
            nxt_wdt_irq = !WATCHDOG_RESET_SELECT_OPTION_I && IRQ_GLOBAL_EN_I;
          end
        end
      end
      default: begin
        nxt_state = S_RUN;
      end
    endcase
  end

  // Sticky reset cause; a new cause wins over a clear
  always_comb begin
    nxt_cause = cause_ff;
    if (FLAG_CLR_I) begin
      nxt_cause = '0;
    end
    if (POR_I) nxt_cause.por = 1'b1;
    if (BROWNOUT_DETECT_I) nxt_cause.brownout = 1'b1;
    if (wdt_rst_en) nxt_cause.watchdog = 1'b1;
    if (pin_rst_en || stop_pin_rst) nxt_cause.pin = 1'b1;
    if (DEBUGGER_CONTROL_REGISTER_I[DBG_CTL_RESET_BIT]) nxt_cause.debug = 1'b1;
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_ff       <= S_RUN;
      smr_cnt_ff     <= '0;
      pulse_cnt_ff   <= '0;
      gpio_ref_ff    <= '0;
      pin_data_ff    <= '0;
      wake_by_wdt_ff <= 1'b0;
      wake_by_pin_ff <= 1'b0;
      flags_ff       <= '0;
      cause_ff       <= '0;
      wdt_irq_ff     <= 1'b0;
    end else if (CE_I) begin
      if (rst_stretched) begin
        state_ff       <= S_RUN;
        smr_cnt_ff     <= '0;
        pulse_cnt_ff   <= '0;
        wake_by_wdt_ff <= 1'b0;
        wake_by_pin_ff <= 1'b0;
        flags_ff       <= '0;
        wdt_irq_ff     <= 1'b0;
        pin_data_ff    <= nxt_pin_data;
        gpio_ref_ff    <= nxt_gpio_ref;
      end else begin
        state_ff       <= nxt_state;
        smr_cnt_ff     <= nxt_smr_cnt;
        pulse_cnt_ff   <= nxt_pulse_cnt;
        gpio_ref_ff    <= nxt_gpio_ref;
        pin_data_ff    <= nxt_pin_data;
        wake_by_wdt_ff <= nxt_wake_by_wdt;
        wake_by_pin_ff <= nxt_wake_by_pin;
        flags_ff       <= nxt_flags;
        wdt_irq_ff     <= nxt_wdt_irq;
      end
      cause_ff <= nxt_cause;
    end
  end

  // Registered outputs
  logic                stop_ff;
  logic                halt_ff;
  logic                cpu_run_ff;
  logic                sys_clk_en_ff;
  logic                wdt_clk_en_ff;
  logic [PERIPH_N-1:0] periph_en_ff;

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sys_rst_ff    <= 1'b1;
      cpu_run_ff    <= 1'b0;
      stop_ff       <= 1'b0;
      halt_ff       <= 1'b0;
      sys_clk_en_ff <= 1'b1;
      wdt_clk_en_ff <= 1'b1;
      periph_en_ff  <= '0;
    end else if (CE_I) begin
      sys_rst_ff    <= rst_stretched;
      cpu_run_ff    <= !rst_stretched && (nxt_state == S_RUN);
      sys_clk_en_ff <= rst_stretched || !(nxt_state == S_STOP);
      wdt_clk_en_ff <= WDT_ENABLE_I || nxt_state != S_STOP;
      periph_en_ff  <= rst_stretched ? '0 : ~PERIPH_DISABLE_I;
      stop_ff       <= !rst_stretched && (nxt_state == S_STOP);
      halt_ff       <= !rst_stretched && (nxt_state == S_HALT);
    end
  end

  assign SYS_RESET_O                = sys_rst_ff;
  assign RESET_PIN_O                = 1'b0;
  assign RESET_PIN_OE_O             = sys_rst_ff;
  assign RESET_CAUSE_O              = cause_ff;
  assign WAKE_FLAGS_O               = flags_ff;
  assign CPU_RUN_O                  = cpu_run_ff;
  assign SYS_CLK_EN_O               = sys_clk_en_ff;
  assign WDT_CLK_EN_O               = wdt_clk_en_ff;
  assign WDT_IRQ_O                  = wdt_irq_ff;
  assign PORT_INPUT_DATA_REGISTER_O = pin_data_ff;
  assign STOP_O                     = stop_ff;
  assign HALT_O                     = halt_ff;
  assign PERIPH_CLK_EN_O            = periph_en_ff;
  assign PERIPH_PWR_EN_O            = periph_en_ff;

endmodule

// *** dv/reset_stop_halt_controller_asserts.sv ***
// Purpose: Port-level timing checks for the reset, stop and halt controller
// Assumes: CE_I held high; pin input fed from the resolved open-drain line
// Notes:   Bound from the bench top file
module reset_stop_halt_controller_asserts
  import rst_ctl_pkg::*;
#(
  parameter int unsigned GPIO_N   = 24,
  parameter int unsigned PERIPH_N = 8
) (
  input wire logic                REF_CLK_I,
  input wire logic                RST_I,
  input wire logic                POR_I,
  input wire logic                BROWNOUT_DETECT_I,
  input wire logic                WDT_TIMEOUT_I,
  input wire logic                WATCHDOG_RESET_SELECT_OPTION_I,
  input wire logic                RESET_PIN_I,
  input wire logic                RESET_PIN_ALT_EN_I,
  input wire logic [7:0]          DEBUGGER_CONTROL_REGISTER_I,
  input wire logic [PERIPH_N-1:0] PERIPH_DISABLE_I,
  input wire logic                RESET_PIN_O,
  input wire logic                RESET_PIN_OE_O,
  input wire logic                SYS_RESET_O,
  input wire logic                CPU_RUN_O,
  input wire logic                SYS_CLK_EN_O,
  input wire logic                WDT_CLK_EN_O,
  input wire logic                WDT_IRQ_O,
  input wire logic                STOP_O,
  input wire logic                HALT_O,
  input wire logic [GPIO_N-1:0]   PORT_INPUT_DATA_REGISTER_O,
  input wire logic [PERIPH_N-1:0] PERIPH_CLK_EN_O,
  input wire logic [PERIPH_N-1:0] PERIPH_PWR_EN_O
);
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);

  oe_tracks_rst_a: assert property (RESET_PIN_OE_O == SYS_RESET_O)
    else $error("reset pin enable differs from system reset");
  pin_sinks_low_a: assert property (RESET_PIN_OE_O |-> !RESET_PIN_O)
    else $error("reset pin data not low while enabled");
  supply_reset_a: assert property ((POR_I || BROWNOUT_DETECT_I)[*2] |-> ##[0:3] SYS_RESET_O)
    else $error("supply source gave no reset");
  debug_reset_a: assert property (DEBUGGER_CONTROL_REGISTER_I[0] [*2] |-> ##[0:3] SYS_RESET_O)
    else $error("debugger request gave no reset");
  pin_reset_a: assert property ((!RESET_PIN_I && RESET_PIN_ALT_EN_I)[*2] |-> ##[0:3] SYS_RESET_O)
    else $error("reset pin gave no reset");
  wdog_reset_a: assert property
    ((WDT_TIMEOUT_I && WATCHDOG_RESET_SELECT_OPTION_I && CPU_RUN_O)[*2] |-> ##[0:3] SYS_RESET_O)
    else $error("watchdog reset option gave no reset");
  halt_clocks_a: assert property (HALT_O [*2] |-> SYS_CLK_EN_O && WDT_CLK_EN_O && !CPU_RUN_O)
    else $error("halt state clocks or cpu wrong");
  periph_gate_a: assert property ((!SYS_RESET_O)[*3] |->
    {PERIPH_CLK_EN_O, PERIPH_PWR_EN_O} == {2{~$past(PERIPH_DISABLE_I)}})
    else $error("peripheral enables do not follow disables");
  irq_single_a: assert property (WDT_IRQ_O |=> !WDT_IRQ_O)
    else $error("watchdog request longer than one cycle");
  port_frozen_a: assert property (STOP_O && $past(STOP_O) |-> $stable(PORT_INPUT_DATA_REGISTER_O))
    else $error("port data changed in stop");
  stop_gates_a: assert property (STOP_O [*2] |-> !SYS_CLK_EN_O && !CPU_RUN_O)
    else $error("clock or cpu running in stop");
endmodule

// *** dv/rst_pin_party.sv ***
// Purpose: Far side of the open-drain reset line with its pull-up
// Assumes: Parties only sink the line, nobody drives it high
// Notes:   Resolved level feeds the controller's pin input
module rst_pin_party (
  input  wire logic oe_i,
  input  wire logic data_i,
  input  wire logic ext_low_i,
  output logic      pin_o
);
  // Pull-up wins unless someone sinks the line
  assign pin_o = ~((oe_i & ~data_i) | ext_low_i);
endmodule

// *** dv/reset_stop_halt_controller_bench.sv ***
// Purpose: Self-checking bench for the reset, stop and halt controller
// Assumes: Short hold counts; inputs change on the falling edge
// Notes:   Reset line resolved by the pin party model
module reset_stop_halt_controller_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import rst_ctl_pkg::*;
  localparam int STOP_RECOVERY = 8;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, por = 1'b0, bo = 1'b0, wdog = 1'b0, wsel = 1'b0;
  logic ext_low = 1'b0, alt = 1'b0, sdp = 1'b1, xtal = 1'b0, stp = 1'b0, hlt = 1'b0;
  logic irq = 1'b0, fclr = 1'b0, pin_lvl, rp_o, oe, sres, run, sce, wce, wirq, stop, halt;
  logic wen = 1'b1, ien = 1'b1;
  logic [7:0] dctl = 8'h00, pdis = 8'h00, pclk, ppwr;
  logic [23:0] gpio = 24'h000000, wake_en = 24'h000020, pdat;
  rst_cause_t cause;
  wake_flags_t wake;
  int error_cnt = 0;
  int comparisons = 0;
  always #2 clk = ~clk;
  rst_pin_party party (.oe_i(oe), .data_i(rp_o), .ext_low_i(ext_low), .pin_o(pin_lvl));
  reset_stop_halt_controller #(.HOLD_CYC(4), .XTAL_CYC(4), .SMR_CYC(STOP_RECOVERY), .PULSE_CYC(2)) uut (
    .REF_CLK_I(clk), .RST_I(rst), .CE_I(ce), .POR_I(por), .BROWNOUT_DETECT_I(bo),
    .WDT_TIMEOUT_I(wdog), .WATCHDOG_RESET_SELECT_OPTION_I(wsel), .WDT_ENABLE_I(wen),
    .RESET_PIN_I(pin_lvl), .RESET_PIN_ALT_EN_I(alt), .DEBUGGER_CONTROL_REGISTER_I(dctl),
    .SERIAL_DEBUG_PIN_I(sdp), .XTAL_OPTION_I(xtal), .STOP_REQ_I(stp), .HALT_REQ_I(hlt),
    .IRQ_PENDING_I(irq), .IRQ_GLOBAL_EN_I(ien), .GPIO_I(gpio), .SMR_SRC_EN_I(wake_en),
    .FLAG_CLR_I(fclr), .PERIPH_DISABLE_I(pdis), .RESET_PIN_O(rp_o), .RESET_PIN_OE_O(oe),
    .SYS_RESET_O(sres), .RESET_CAUSE_O(cause), .WAKE_FLAGS_O(wake), .CPU_RUN_O(run),
    .SYS_CLK_EN_O(sce), .WDT_CLK_EN_O(wce), .WDT_IRQ_O(wirq),
    .PORT_INPUT_DATA_REGISTER_O(pdat), .STOP_O(stop), .HALT_O(halt),
    .PERIPH_CLK_EN_O(pclk), .PERIPH_PWR_EN_O(ppwr));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic wait_lvl(input int sel, input logic lvl, input int lim);
    int n;
    n = 0;
    while ((sel == 0 ? sres : run) !== lvl) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        chk("wait_limit", 1'b0, 1'b1);
        results();
      end
    end
  endtask

  // One-cycle pulse: 0 flag clear, 1 stop request, other halt request
  task automatic step(input int w);
    case (w)
      0: fclr = 1'b1;
      1: stp = 1'b1;
      default: hlt = 1'b1;
    endcase
    @(negedge clk);
    fclr = 1'b0;
    stp = 1'b0;
    hlt = 1'b0;
    @(negedge clk);
  endtask

  task automatic drive_src(input int s, input logic on);
    case (s)
      0: por = on;
      1: bo = on;
      2: wdog = on;
      3: begin
        ext_low = on;
        alt = 1'b1;
      end
      default: dctl[0] = on;
    endcase
  endtask

  task automatic t_sources();
    wsel = 1'b1;
    for (int s = 0; s < 5; s++) begin
      step(0);
      drive_src(s, 1'b1);
      wait_lvl(0, 1'b1, 8);
      chk("pin_low", {oe, pin_lvl}, 2'b10);
      drive_src(s, 1'b0);
      wait_lvl(0, 1'b0, 40);
      chk("cause", cause, 5'h10 >> s);
    end
    wsel = 1'b0;
  endtask

  task automatic t_gated();
    alt = 1'b0;
    ext_low = 1'b1;
    wdog = 1'b1;
    repeat (10) @(negedge clk);
    chk("no_reset", sres, 1'b0);
    ext_low = 1'b0;
    wdog = 1'b0;
  endtask

  task automatic t_xtal();
    int len[2];
    for (int x = 0; x < 2; x++) begin
      xtal = x[0];
      dctl[0] = 1'b1;
      wait_lvl(0, 1'b1, 8);
      dctl[0] = 1'b0;
      len[x] = 0;
      while (sres === 1'b1 && len[x] < 200) begin
        @(negedge clk);
        len[x]++;
      end
    end
    xtal = 1'b0;
    chk("xtal_len", len[1] - len[0], 4);
  endtask

  task automatic enter_stop();
    step(1);
    @(negedge clk);
    chk("stop", {stop, sce, run, wce}, {3'b100, wen});
  endtask

  task automatic t_pin_wake();
    for (int d = 0; d < 2; d++) begin
      step(0);
      enter_stop();
      gpio[5] = ~gpio[5];
      wait_lvl(1, 1'b1, 40);
      @(negedge clk);
      chk("wake", {wake, sce, sres}, 5'b01010);
      chk("pdat", pdat[5], gpio[5]);
    end
  endtask

  task automatic t_short_then_wdog();
    logic irq_seen;
    for (int k = 0; k < 3; k++) begin
      step(0);
      enter_stop();
      gpio[5] = ~gpio[5];
      @(negedge clk);
      gpio[5] = ~gpio[5];
      repeat (STOP_RECOVERY + 6) @(negedge clk);
      chk("short", {stop, run, wake}, 5'b10001);
      wsel = (k == 1);
      ien = (k != 2);
      wdog = 1'b1;
      @(negedge clk);
      wdog = 1'b0;
      irq_seen = 1'b0;
      repeat (STOP_RECOVERY + 12) begin
        @(negedge clk);
        irq_seen |= wirq;
      end
      chk("wdog_wake", {run, sres, wake}, 5'b10111);
      chk("wdog_irq", irq_seen, k == 0);
    end
    wsel = 1'b0;
    ien = 1'b1;
  endtask

  task automatic t_stop_reset();
    for (int k = 0; k < 2; k++) begin
      wen = k[0];
      enter_stop();
      if (k == 0) drive_src(3, 1'b1);
      else sdp = 1'b0;
      wait_lvl(0, 1'b1, 8);
      chk("stop_rst", stop, 1'b0);
      drive_src(3, 1'b0);
      sdp = 1'b1;
      wait_lvl(1, 1'b1, 40);
    end
    wen = 1'b1;
  endtask

  task automatic t_halt();
    pdis = 8'hA5;
    for (int k = 0; k < 2; k++) begin
      step(2);
      @(negedge clk);
      chk("halt", {halt, run, sce, wce}, 4'b1011);
      chk("periph", {pclk, ppwr}, 16'h5A5A);
      if (k == 0) irq = 1'b1;
      else wdog = 1'b1;
      wait_lvl(1, 1'b1, 8);
      chk("halt_exit", {halt, sres}, 2'b00);
      irq = 1'b0;
      wdog = 1'b0;
    end
    pdis = 8'h00;
  endtask

  initial begin
    repeat (8) @(negedge clk);
    chk("in_reset", {sres, oe}, 2'b11);
    rst = 1'b0;
    wait_lvl(1, 1'b1, 40);
    t_sources();
    t_gated();
    t_xtal();
    t_pin_wake();
    t_short_then_wdog();
    t_stop_reset();
    t_halt();
    results();
  end
endmodule

bind reset_stop_halt_controller reset_stop_halt_controller_asserts #(
  .GPIO_N(GPIO_N), .PERIPH_N(PERIPH_N)) chk_i (
  .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .POR_I(POR_I), .BROWNOUT_DETECT_I(BROWNOUT_DETECT_I),
  .WDT_TIMEOUT_I(WDT_TIMEOUT_I),
  .WATCHDOG_RESET_SELECT_OPTION_I(WATCHDOG_RESET_SELECT_OPTION_I),
  .RESET_PIN_I(RESET_PIN_I), .RESET_PIN_ALT_EN_I(RESET_PIN_ALT_EN_I),
  .DEBUGGER_CONTROL_REGISTER_I(DEBUGGER_CONTROL_REGISTER_I),
  .PERIPH_DISABLE_I(PERIPH_DISABLE_I), .RESET_PIN_O(RESET_PIN_O),
  .RESET_PIN_OE_O(RESET_PIN_OE_O), .SYS_RESET_O(SYS_RESET_O), .CPU_RUN_O(CPU_RUN_O),
  .SYS_CLK_EN_O(SYS_CLK_EN_O), .WDT_CLK_EN_O(WDT_CLK_EN_O), .WDT_IRQ_O(WDT_IRQ_O),
  .STOP_O(STOP_O), .HALT_O(HALT_O),
  .PORT_INPUT_DATA_REGISTER_O(PORT_INPUT_DATA_REGISTER_O),
  .PERIPH_CLK_EN_O(PERIPH_CLK_EN_O), .PERIPH_PWR_EN_O(PERIPH_PWR_EN_O));
